// ===== core/dacp_buf2.sv
`timescale 1ns/100ps
`default_nettype none
// Two-entry buffer with valid/ready on both sides; ready is registered
module dacp_buf2 #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  import dacp_pkg::*;

  logic [WIDTH-1:0] mem_q [2];
  logic             wr_ptr_q;
  logic             rd_ptr_q;
  logic [1:0]       occ_q;
  logic [1:0]       occ_d;
  logic             ready_q;
  wire              push = in_valid & ready_q;
  wire              pop  = out_valid & out_ready;

  // Occupancy follows push and pop; both in one cycle leaves it unchanged
  assign occ_d     = push & ~pop ? occ_q + 2'h1 :
                     pop & ~push ? occ_q - 2'h1 : occ_q;
  assign out_valid = (occ_q != OCC_EMPTY);
  assign out_data  = mem_q[rd_ptr_q];
  assign in_ready  = ready_q;

  // Pointers and count; ready is a flop so the source sees a clean level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      occ_q    <= OCC_EMPTY;
      ready_q  <= 1'b0;
    end else if (clear) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      occ_q    <= OCC_EMPTY;
      ready_q  <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      occ_q    <= occ_d;
      ready_q  <= (occ_d != OCC_FULL);
    end
  end

  // Storage has no reset; only valid entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule
`default_nettype wire

// ===== core/dacp_pin_ctrl.sv
// Behaviour
// RQ1 - In PLL clock mode the lock output is high while the PLL reports lock.
// RQ2 - In external clock mode the lock output carries the input-rate clock.
// RQ3 - In interleaved mode with the flag enable set, the channel flag pin is driven as an output.
// RQ4 - The driven channel flag is high for channel B words and low for channel A words.
// RQ5 - All logic is held in reset while the active-low chip reset is low.
// RQ6 - The serial data I/O pin is bidirectional in three-pin mode and input-only in four-pin mode.
// RQ7 - The serial data output is released in three-pin mode and carries read data in four-pin mode.
// RQ8 - The serial enable is an active-low input and frames every serial transfer.
// RQ9 - A high sleep input powers the device down; an undriven sleep input reads low.
// RQ10 - In interleaved mode a gate rising edge makes the next word channel A, then B, alternately.
// RQ11 - While the transmit gate is low both outputs sit at midscale; an undriven gate reads low.
// RQ12 - The factory test select input is held at ground in normal use.
// RQ13 - The data source raises the gate just before a channel A word in interleaved mode.
`timescale 1ns/100ps
`default_nettype none
module dacp_pin_ctrl (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  chip_reset_n,
  input  wire logic                  sleep,
  input  wire logic                  factory_test_select,
  input  wire logic                  transmit_gate,
  input  wire logic                  interleave_mode,
  input  wire logic                  qflag_enable,
  input  wire logic                  pll_mode,
  input  wire logic                  pll_locked,
  input  wire logic                  in_valid,
  input  wire dacp_pkg::dacp_pair_t  in_pair,
  output logic                       in_ready,
  output dacp_pkg::dacp_out_t        dac_out,
  output logic                       dac_update,
  output logic                       power_down,
  output logic                       pll_lock_out,
  output logic                       qflag_out,
  output logic                       qflag_oe_n,
  input  wire logic                  four_pin_mode,
  input  wire logic                  serial_enable_n,
  input  wire logic                  serial_read_phase,
  input  wire logic                  serial_read_bit,
  input  wire logic                  sdio_in,
  output logic                       serial_write_bit,
  output logic                       sdio_out,
  output logic                       sdio_oe_n,
  output logic                       serial_data_out,
  output logic                       serial_data_out_oe_n
);
  import dacp_pkg::*;

  // Serial pins released: both enables high, data low
  localparam dacp_serial_t SER_IDLE = '{sdio_out: 1'b0, sdio_oe_n: 1'b1, sdo_out: 1'b0, sdo_oe_n: 1'b1};

  // Chip reset is a plain synchronous input; it clears logic as a sync reset
  wire         chip_hold = ~chip_reset_n;                        // RQ5

  // Test select is only sampled into a flag; in normal use it stays low
  logic        test_q;

  // Input-rate divider
  logic [3:0]  rate_cnt_q;
  logic [3:0]  rate_cnt_d;
  wire         rate_en;
  wire         rate_clk_lvl;

  // Gate edge detection and channel steering
  logic        gate_q;
  wire         gate_rise;
  logic        steer_b_q;
  logic        steer_b_d;
  wire         steer_b_now;

  // Buffered stream toward the converters
  wire         buf_valid;
  dacp_pair_t  buf_pair;
  wire         buf_ready;
  wire         buf_ready_int;

  // Output state machine
  dacp_state_t state_q;
  dacp_state_t state_d;

  // Registered outputs
  dacp_out_t    out_q;
  dacp_out_t    out_d;
  logic         upd_q;
  logic         pd_q;
  logic         lock_q;
  logic         lock_d;
  logic         qflag_q;
  logic         qflag_oe_n_q;
  logic         qflag_oe_n_d;
  logic         qflag_d;
  dacp_serial_t ser_q;
  dacp_serial_t ser_d;
  logic         wbit_q;

  // Divider: rate_en marks each input word slot, one clock wide
  assign rate_cnt_d   = (rate_cnt_q == RATE_TOP) ? CNT_ZERO : rate_cnt_q + CNT_ONE;
  assign rate_en      = (rate_cnt_q == RATE_TOP);
  // Input-rate clock is high for the first half of each slot
  assign rate_clk_lvl = (rate_cnt_q < RATE_HALF);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rate_cnt_q <= CNT_ZERO;
    end else if (chip_hold) begin
      rate_cnt_q <= CNT_ZERO;                                    // RQ5
    end else begin
      rate_cnt_q <= rate_cnt_d;
    end
  end

  // Skid buffer absorbs words while the converters are asleep; chip reset empties it,
  // so a source that keeps presenting data during sleep loses nothing
  dacp_buf2 #(
    .WIDTH ($bits(dacp_pair_t))
  ) u_buf (
    .clk       (mclk),
    .rst       (rst),
    .clear     (chip_hold),
    .in_valid  (in_valid),
    .in_data   (in_pair),
    .in_ready  (in_ready),
    .out_valid (buf_valid),
    .out_data  (buf_pair),
    .out_ready (buf_ready)
  );

  // Next state of the output path; sleep outranks the gate
  always_comb begin
    state_d = state_q;
    case (state_q)
      DACP_ST_RESET: begin
        state_d = DACP_ST_MUTE;
      end
      DACP_ST_SLEEP: begin
        if (!sleep) begin
          state_d = DACP_ST_MUTE;
        end
      end
      DACP_ST_MUTE: begin
        if (sleep) begin
          state_d = DACP_ST_SLEEP;                               // RQ9
        end else if (transmit_gate) begin
          state_d = DACP_ST_RUN;
        end
      end
      DACP_ST_RUN: begin
        if (sleep) begin
          state_d = DACP_ST_SLEEP;                               // RQ9
        end else if (!transmit_gate) begin
          state_d = DACP_ST_MUTE;                                // RQ11
        end
      end
      default: begin
        state_d = DACP_ST_RESET;
      end
    endcase
  end

  // Words drain one per slot except in sleep or reset; while muted they are consumed
  // and discarded so the source is not stalled by a closed gate
  assign buf_ready_int = rate_en & (state_q != DACP_ST_SLEEP) & (state_q != DACP_ST_RESET);
  assign buf_ready     = buf_ready_int;

  // Rising gate edge restarts steering at channel A; a word popped on that
  // very edge is already the first A word, so steering is cleared before use
  assign gate_rise   = transmit_gate & ~gate_q;                  // RQ10
  assign steer_b_now = steer_b_q & ~gate_rise;                   // RQ10
  assign steer_b_d   = (buf_valid & buf_ready_int & interleave_mode) ? ~steer_b_now : steer_b_now;

  // Converter words: midscale with the gate low or asleep; a word popped on
  // the cycle the path leaves mute with the gate high is kept, not dropped
  always_comb begin
    out_d = out_q;
    if (!transmit_gate || state_q == DACP_ST_SLEEP || state_q == DACP_ST_RESET) begin
      out_d.out_a = MIDSCALE;                                    // RQ11
      out_d.out_b = MIDSCALE;                                    // RQ11
    end else if (buf_valid && buf_ready_int) begin
      if (!interleave_mode) begin
        out_d.out_a = buf_pair.data_a;
        out_d.out_b = buf_pair.data_b;
      end else if (steer_b_now) begin
        out_d.out_b = buf_pair.data_a;                           // RQ10
      end else begin
        out_d.out_a = buf_pair.data_a;                           // RQ10
      end
    end
  end

  // Lock pin: PLL status or input-rate clock depending on clock mode
  assign lock_d = pll_mode ? pll_locked : rate_clk_lvl;          // RQ1 RQ2

  // Channel flag follows the word just steered; pin released otherwise
  assign qflag_oe_n_d = ~(interleave_mode & qflag_enable);       // RQ3
  assign qflag_d      = (interleave_mode & qflag_enable) ?
                        ((buf_valid & buf_ready_int) ? steer_b_now : qflag_q) : 1'b0; // RQ4

  // Serial pins: drive only inside a frame and only in the read phase
  always_comb begin
    ser_d           = '0;
    ser_d.sdio_oe_n = 1'b1;
    ser_d.sdo_oe_n  = 1'b1;                                      // RQ7
    if (!serial_enable_n && serial_read_phase) begin             // RQ8
      if (four_pin_mode) begin
        ser_d.sdo_out  = serial_read_bit;                        // RQ7
        ser_d.sdo_oe_n = 1'b0;                                   // RQ7
      end else begin
        ser_d.sdio_out  = serial_read_bit;                       // RQ6
        ser_d.sdio_oe_n = 1'b0;                                  // RQ6
      end
    end
  end

  // Control state: gate history, steering, path state, test flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gate_q    <= 1'b0;
      steer_b_q <= 1'b0;
      state_q   <= DACP_ST_RESET;
      test_q    <= 1'b0;
    end else if (chip_hold) begin
      gate_q    <= 1'b0;                                         // RQ5
      steer_b_q <= 1'b0;
      state_q   <= DACP_ST_RESET;
      test_q    <= 1'b0;
    end else begin
      gate_q    <= transmit_gate;
      steer_b_q <= steer_b_d;
      state_q   <= state_d;
      test_q    <= factory_test_select;                          // RQ12
    end
  end

  // Converter outputs and update strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_q <= {MIDSCALE, MIDSCALE};
      upd_q <= 1'b0;
    end else if (chip_hold) begin
      out_q <= {MIDSCALE, MIDSCALE};                             // RQ5
      upd_q <= 1'b0;
    end else begin
      out_q <= out_d;
      upd_q <= rate_en & (state_q != DACP_ST_SLEEP);
    end
  end

  // Power-down follows sleep each clock; test select forces nothing here,
  // a raised test pin is simply ignored so a stray level cannot hang the part
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pd_q <= 1'b0;
    end else if (chip_hold) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= sleep;                                             // RQ9
    end
  end

  // Lock pin and channel flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lock_q       <= 1'b0;
      qflag_q      <= 1'b0;
      qflag_oe_n_q <= 1'b1;
    end else if (chip_hold) begin
      lock_q       <= 1'b0;
      qflag_q      <= 1'b0;
      qflag_oe_n_q <= 1'b1;
    end else begin
      lock_q       <= lock_d;                                    // RQ1 RQ2
      qflag_q      <= qflag_d;                                   // RQ4
      qflag_oe_n_q <= qflag_oe_n_d;                              // RQ3
    end
  end

  // Serial pin drivers and captured write bit; released in reset so a
  // controller driving SDIO never fights the device
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ser_q  <= SER_IDLE;
      wbit_q <= 1'b0;
    end else if (chip_hold) begin
      ser_q  <= SER_IDLE;
      wbit_q <= 1'b0;
    end else begin
      ser_q  <= ser_d;
      wbit_q <= (!serial_enable_n && !serial_read_phase) ? sdio_in : wbit_q; // RQ6 RQ8
    end
  end

  // Port drive, all from flops
  assign dac_out              = out_q;
  assign dac_update           = upd_q;
  assign power_down           = pd_q;
  assign pll_lock_out         = lock_q;
  assign qflag_out            = qflag_q;
  assign qflag_oe_n           = qflag_oe_n_q;
  assign serial_write_bit     = wbit_q;
  assign sdio_out             = ser_q.sdio_out;
  assign sdio_oe_n            = ser_q.sdio_oe_n;
  assign serial_data_out      = ser_q.sdo_out;
  assign serial_data_out_oe_n = ser_q.sdo_oe_n;

endmodule
`default_nettype wire

// ===== core/dacp_pkg.sv
// Shared constants and carriers for the converter pin-control block
package dacp_pkg;

  // Converter word width and the code that puts an output at midscale
  localparam int          WORD_W   = 16;
  localparam logic [15:0] MIDSCALE = 16'h8000;

  // Input-rate divider: one word slot every RATE_DIV clocks
  localparam int          CNT_W    = 4;
  localparam logic [3:0]  RATE_DIV = 4'h4;
  localparam logic [3:0]  RATE_TOP = 4'h3;
  localparam logic [3:0]  RATE_HALF = 4'h2;
  localparam logic [3:0]  CNT_ZERO = 4'h0;
  localparam logic [3:0]  CNT_ONE  = 4'h1;

  // Buffer occupancy codes for the two-entry skid buffer
  localparam logic [1:0]  OCC_EMPTY = 2'h0;
  localparam logic [1:0]  OCC_ONE   = 2'h1;
  localparam logic [1:0]  OCC_FULL  = 2'h2;

  // One input slot: a word for each channel
  typedef struct packed {
    logic [15:0] data_a;
    logic [15:0] data_b;
  } dacp_pair_t;

  // Word pair presented to the two converters
  typedef struct packed {
    logic [15:0] out_a;
    logic [15:0] out_b;
  } dacp_out_t;

  // Serial pin drive set, output enables active low
  typedef struct packed {
    logic sdio_out;
    logic sdio_oe_n;
    logic sdo_out;
    logic sdo_oe_n;
  } dacp_serial_t;

  // Operating state of the output path
  typedef enum logic [1:0] {
    DACP_ST_RESET,
    DACP_ST_SLEEP,
    DACP_ST_MUTE,
    DACP_ST_RUN
  } dacp_state_t;

endpackage

// ===== test/dacp_pin_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level timing relations of the pin-control block
module dacp_pin_ctrl_asserts (
  input wire logic                mclk,
  input wire logic                rst,
  input wire logic                chip_reset_n,
  input wire logic                sleep,
  input wire logic                transmit_gate,
  input wire logic                interleave_mode,
  input wire logic                qflag_enable,
  input wire logic                pll_mode,
  input wire logic                pll_locked,
  input wire dacp_pkg::dacp_out_t dac_out,
  input wire logic                dac_update,
  input wire logic                power_down,
  input wire logic                pll_lock_out,
  input wire logic                qflag_oe_n,
  input wire logic                four_pin_mode,
  input wire logic                serial_enable_n,
  input wire logic                serial_read_phase,
  input wire logic                serial_read_bit,
  input wire logic                sdio_oe_n,
  input wire logic                serial_data_out,
  input wire logic                serial_data_out_oe_n
);
  import dacp_pkg::*;
  localparam dacp_out_t MID = {MIDSCALE, MIDSCALE};
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Two edges out of chip reset, so a registered output reflects its inputs
  sequence run2;
    chip_reset_n ##1 chip_reset_n;
  endsequence
  // Long enough in external mode for two rate-clock phases to show
  sequence rate_run;
    (!pll_mode && chip_reset_n)[*5];
  endsequence
  lock_follow_a: assert property ((pll_mode && chip_reset_n ##1 chip_reset_n) |->
    pll_lock_out == $past(pll_locked)) else $error("lock output not following lock status");
  rate_clock_a: assert property (rate_run |-> pll_lock_out != $past(pll_lock_out, 2))
    else $error("rate clock not high two of four cycles");
  midscale_a: assert property (!transmit_gate |=> dac_out == MID)
    else $error("outputs not at midscale with gate low");
  power_down_a: assert property (run2 |-> power_down == $past(sleep))
    else $error("power down not following sleep");
  chip_reset_a: assert property (!chip_reset_n |=> dac_out == MID && !dac_update && qflag_oe_n &&
    sdio_oe_n && serial_data_out_oe_n) else $error("chip reset did not clear outputs");
  sdio_dir_a: assert property (run2 |->
    sdio_oe_n == !$past(!four_pin_mode && !serial_enable_n && serial_read_phase))
    else $error("data pin direction wrong");
  serial_out_dir_a: assert property (run2 |->
    serial_data_out_oe_n == !$past(four_pin_mode && !serial_enable_n && serial_read_phase))
    else $error("serial output enable wrong");
  serial_data_a: assert property (!serial_data_out_oe_n |-> serial_data_out == $past(serial_read_bit))
    else $error("serial output data wrong");
  qflag_drive_a: assert property (run2 |-> qflag_oe_n == !$past(interleave_mode && qflag_enable))
    else $error("channel flag drive wrong");
  slot_rate_a: assert property (dac_update |=> !dac_update [*3])
    else $error("slot pulses closer than four cycles");
endmodule
bind dacp_pin_ctrl dacp_pin_ctrl_asserts dacp_pin_ctrl_asserts_inst (.*);
`default_nettype wire

// ===== test/dacp_src_model.sv
`timescale 1ns/100ps
`default_nettype none
// Baseband data source: offers word pairs, holds each until taken
module dacp_src_model (
  input  wire logic           mclk,
  input  wire logic           go,
  input  wire logic           stall,
  input  wire logic           in_ready,
  output logic                in_valid,
  output dacp_pkg::dacp_pair_t in_pair,
  output logic [15:0]         rnd
);
  import dacp_pkg::*;
  logic taken;
  // Maximal-length shift register; fixed start keeps runs repeatable
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  initial begin
    rnd = 16'hd49e;
    in_valid = 1'b0;
    in_pair = '0;
    taken = 1'b0;
  end
  // Handshake completes on the edge where valid and ready are both high
  always @(posedge mclk) taken <= in_valid && in_ready;
  // Idle bus keeps changing so stale data never passes for a word
  always @(negedge mclk) begin
    rnd <= lfsr(rnd);
    if (taken || !in_valid) begin
      in_valid <= go && !stall;
      in_pair <= (go && !stall) ? {rnd, lfsr(rnd)} : ~in_pair;
    end
  end
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the converter pin-control block
module testbench;
  import dacp_pkg::*;
  logic       mclk, rst, chip_reset_n, sleep, transmit_gate, interleave_mode, qflag_enable, pll_mode;
  logic       pll_locked, four_pin_mode, serial_enable_n, serial_read_phase, serial_read_bit, tb_sdio;
  logic       go, stall, in_valid, in_ready, dac_update, power_down, pll_lock_out, qflag_out, qflag_oe_n;
  logic       serial_write_bit, sdio_out, sdio_oe_n, serial_data_out, serial_data_out_oe_n, sdio_in, chk_on, chan;
  logic [15:0] rnd;
  dacp_pair_t in_pair;
  dacp_out_t  dac_out;
  dacp_pair_t q[$];
  int         mismatches = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         k;
  logic       took_now = 1'b0;
  dacp_pin_ctrl dacp_pin_ctrl_inst (.mclk, .rst, .chip_reset_n, .sleep, .factory_test_select(1'b0),
    .transmit_gate, .interleave_mode, .qflag_enable, .pll_mode, .pll_locked, .in_valid, .in_pair, .in_ready,
    .dac_out, .dac_update, .power_down, .pll_lock_out, .qflag_out, .qflag_oe_n, .four_pin_mode,
    .serial_enable_n, .serial_read_phase, .serial_read_bit, .sdio_in, .serial_write_bit, .sdio_out,
    .sdio_oe_n, .serial_data_out, .serial_data_out_oe_n);
  dacp_src_model dacp_src_model_inst (.mclk, .go, .stall, .in_ready, .in_valid, .in_pair, .rnd);
  // Pin level: design drives only while its enable is low
  assign sdio_in = sdio_oe_n ? tb_sdio : sdio_out;
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      summarize();
    end
  end
  // Taken words queue in order; an empty queue means an empty slot
  // A word taken on a slot edge cannot leave the buffer on that same edge
  always @(posedge mclk) begin
    took_now <= in_valid && in_ready;
    if (in_valid && in_ready) q.push_back(in_pair);
  end
  // Each slot pulse shows one pair, or one word steered A then B
  always @(negedge mclk) begin
    dacp_pair_t w;
    if (chk_on && dac_update && q.size() > int'(took_now)) begin
      w = q.pop_front();
      if (!interleave_mode) begin
        chk(dac_out, w);
      end else begin
        chk(chan ? dac_out.out_b : dac_out.out_a, w.data_a);
        chk(qflag_out, chan);
        chan = !chan;
      end
    end
  end
  // Fill under sleep until refused, then open the gate and stream with stalls
  task automatic stream(input logic il);
    interleave_mode = il;
    transmit_gate = 1'b0;
    repeat (20) @(negedge mclk);
    sleep = 1'b1;
    repeat (2) @(negedge mclk);
    chk({power_down, qflag_oe_n}, {1'b1, !il});
    q.delete();
    go = 1'b1;
    for (k = 0; k < 10 && in_ready !== 1'b0; k++) @(negedge mclk);
    chk({in_ready, dac_update}, 2'h0);
    chan = 1'b0;
    chk_on = 1'b1;
    transmit_gate = 1'b1;
    sleep = 1'b0;
    repeat (40) begin
      @(negedge mclk);
      stall = rnd[1:0] == 2'h0;
    end
    {go, stall} = 2'h0;
    repeat (20) @(negedge mclk);
    chk({in_ready, q.size() == 0}, 2'h3);
    chk_on = 1'b0;
    transmit_gate = 1'b0;
    @(negedge mclk);
    chk(dac_out, {MIDSCALE, MIDSCALE});
    $display("stream test done, interleave %0d", il);
  endtask
  initial begin
    {sleep, transmit_gate, interleave_mode, pll_mode, pll_locked, four_pin_mode, serial_read_phase} = '0;
    {serial_read_bit, tb_sdio, go, stall, chk_on, chan} = '0;
    {rst, chip_reset_n, serial_enable_n, qflag_enable} = 4'hf;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    pll_mode = 1'b1;
    repeat (6) begin
      pll_locked = rnd[3];
      @(negedge mclk);
      chk(pll_lock_out, pll_locked);
    end
    pll_mode = 1'b0;
    k = 0;
    repeat (4) @(negedge mclk);
    repeat (8) begin
      @(negedge mclk);
      k += pll_lock_out;
    end
    chk(k, 4);
    $display("lock output test done");
    for (int i = 0; i < 4; i++) begin
      {four_pin_mode, serial_read_phase} = i[1:0];
      serial_enable_n = 1'b0;
      serial_read_bit = rnd[5];
      tb_sdio = rnd[6];
      @(negedge mclk);
      chk({sdio_oe_n, serial_data_out_oe_n}, {four_pin_mode || !serial_read_phase,
        !four_pin_mode || !serial_read_phase});
      if (serial_read_phase) chk(four_pin_mode ? serial_data_out : sdio_out, serial_read_bit);
      else chk(serial_write_bit, tb_sdio);
      // Close the frame so a read turnaround never overlaps our next drive
      serial_enable_n = 1'b1;
      @(negedge mclk);
      chk({sdio_oe_n, serial_data_out_oe_n}, 2'h3);
    end
    serial_enable_n = 1'b1;
    @(negedge mclk);
    chk({sdio_oe_n, serial_data_out_oe_n}, 2'h3);
    $display("serial pin test done");
    {go, transmit_gate} = 2'h3;
    repeat (9) @(negedge mclk);
    chip_reset_n = 1'b0;
    @(negedge mclk);
    chk({dac_out, in_ready, qflag_oe_n}, {MIDSCALE, MIDSCALE, 2'h1});
    {chip_reset_n, go} = 2'h2;
    $display("chip reset test done");
    stream(1'b0);
    stream(1'b1);
    qflag_enable = 1'b0;
    repeat (2) @(negedge mclk);
    chk(qflag_oe_n, 1'b1);
    $display("flag release test done");
    summarize();
  end
endmodule
`default_nettype wire
